// *** rtl/b2s_params.svh ***
// Constants for the two-word burst DDR SRAM data port.
// Assumes inclusion by the package, the port module and both bench files.
`ifndef B2S_PARAMS_SVH
`define B2S_PARAMS_SVH

// Data bus width: 18 for the narrow build, 36 for the wide one
`define B2S_DQ_W 18
// Bits in one byte lane
`define B2S_LANE_W 9
// Byte lanes on the data bus
`define B2S_LANES (`B2S_DQ_W / `B2S_LANE_W)
// Upper address bits kept in flip-flop storage
`define B2S_ADDR_W 4
// Words in one burst
`define B2S_BURST_LEN 2
// Flip-flops on every pin input
`define B2S_SYNC_STAGES 3
// Pin clocks watched: k, k_n, c, c_n
`define B2S_NCLK 4
// Positions of the pin clocks in the watched vector
`define B2S_CLK_K 0
`define B2S_CLK_KN 1
`define B2S_CLK_C 2
`define B2S_CLK_CN 3
// Data output level after reset
`define B2S_DQ_RST 'h0

`endif

// *** rtl/b2s_pkg.sv ***
// Types shared by the burst SRAM data port.
// Assumes b2s_params.svh sits in the include path.
`include "b2s_params.svh"

package b2s_pkg;

  // Write burst progress, Gray coded along idle, beat 0, beat 1
  typedef enum logic [1:0]
  {
    B2S_W_IDLE = 2'h0,
    B2S_W_BEAT0 = 2'h1,
    B2S_W_BEAT1 = 2'h3
  } b2s_wr_state_t;

  // Read burst progress, Gray coded around the ring
  typedef enum logic [1:0]
  {
    B2S_R_IDLE = 2'h0,
    B2S_R_PEND = 2'h1,
    B2S_R_BEAT0 = 2'h3,
    B2S_R_BEAT1 = 2'h2
  } b2s_rd_state_t;

  // Synchronous pin group sampled together with the k clocks
  typedef struct packed
  {
    logic load_n;
    logic dir_read;
    logic [`B2S_ADDR_W-1:0] addr;
    logic burst_start_bit;
    logic [`B2S_LANES-1:0] byte_write_sel_n;
    logic [`B2S_DQ_W-1:0] dq;
  } b2s_bus_t;

endpackage : b2s_pkg

// *** rtl/b2s_data_port.sv ***
// Data and control port of a two-word burst DDR SRAM, device side.
// Assumes the pin clocks are far slower than clk so that every pin edge
// is seen after three flip-flops; the board resolves the dq wire.
`timescale 1ns/100ps
`default_nettype none
`include "b2s_params.svh"

// Summary of operation
// R1 - Capture write data on k and k_n
// R2 - Drive read data on c and c_n
// R3 - Single clock mode launches on k, k_n
// R4 - Tristate outputs when no read selected
// R5 - Data bus 18 or 36 bits wide
// R6 - Controller pulls load_n low per new cycle
// R7 - Load samples address and direction together
// R8 - Every transfer is exactly two words
// R9 - Direction high reads, low writes
// R10 - Byte selects gate 9-bit lanes
// R11 - Address LSB seeds linear burst counter
// R12 - Word 0 on rising, word 1 on negative edge
module b2s_data_port
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin clocks from the controller
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  // Static strap: launch read data on the k clocks
  input wire logic single_clk_mode,
  // Command pins
  input wire logic load_n,
  input wire logic dir_read,
  input wire logic [`B2S_ADDR_W-1:0] addr,
  input wire logic burst_start_bit,
  input wire logic [`B2S_LANES-1:0] byte_write_sel_n,
  // Shared data pins, split into three signals
  input wire logic [`B2S_DQ_W-1:0] dq_in, // R5
  output logic [`B2S_DQ_W-1:0] dq_out,
  output logic dq_oe_n
);

  // ********************************
  // Pin synchronisers
  // ********************************

  // Clock pins and strap, three flip-flops each
  logic [`B2S_NCLK:0] pin_s1, pin_s2, pin_s3;
  // Settled level of each clock pin and the strap
  logic [`B2S_NCLK:0] pin_lvl;
  // One-cycle rise pulse per clock pin
  logic [`B2S_NCLK-1:0] pin_rise;
  // Command group delayed to match the clock pipeline
  b2s_pkg::b2s_bus_t bus_s1, bus_s2, bus_s3;
  b2s_pkg::b2s_bus_t bus_pin;

  assign bus_pin = '{load_n, dir_read, addr, burst_start_bit, byte_write_sel_n, dq_in};

  // Three flops per pin; stage one feeds only stage two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // All stages start high, matching the settled level below.
      // A pin that idles low then settles with no false rise.
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
      bus_s1 <= '1;
      bus_s2 <= '1;
      bus_s3 <= '1;
    end
    else
    begin
      pin_s1 <= {single_clk_mode, c_n, c, k_n, k};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      bus_s1 <= bus_pin;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end

  // A change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi <= `B2S_NCLK; gi = gi + 1)
    begin : g_lvl
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          pin_lvl[gi] <= 1'b1;
        else if (pin_s2[gi] == pin_s3[gi])
          pin_lvl[gi] <= pin_s3[gi];
      end
    end
    for (gi = 0; gi < `B2S_NCLK; gi = gi + 1)
    begin : g_rise
      assign pin_rise[gi] = pin_s2[gi] & pin_s3[gi] & ~pin_lvl[gi];
    end
  endgenerate

  // Named edge pulses
  logic k_rise, kn_rise, launch_rise, launch_fall, sc_mode;
  assign sc_mode = pin_lvl[`B2S_NCLK];
  assign k_rise = pin_rise[`B2S_CLK_K];
  assign kn_rise = pin_rise[`B2S_CLK_KN];
  // Single clock mode moves the read launch onto the k pair
  assign launch_rise = sc_mode ? k_rise : pin_rise[`B2S_CLK_C]; // R3
  assign launch_fall = sc_mode ? kn_rise : pin_rise[`B2S_CLK_CN]; // R3

  // ********************************
  // Command decode
  // ********************************

  // Write burst state and read burst state
  b2s_pkg::b2s_wr_state_t wr_state;
  b2s_pkg::b2s_rd_state_t rd_state;
  // A load is refused while a write still waits for its first beat,
  // since the controller may only load on alternate k rises
  logic load_ok;
  assign load_ok = k_rise && !bus_s3.load_n && (wr_state != b2s_pkg::B2S_W_BEAT0); // R6

  // Latched burst addresses; the low bit is the one-bit burst counter
  logic [`B2S_ADDR_W-1:0] wr_addr, rd_addr;
  logic wr_lsb, rd_lsb;

  // Storage: plain flip-flops indexed by word address
  logic [`B2S_DQ_W-1:0] mem [0:(2**(`B2S_ADDR_W+1))-1];
  logic wr_en;
  logic [`B2S_ADDR_W:0] wr_idx, rd_idx;
  assign wr_idx = {wr_addr, wr_lsb};
  assign rd_idx = {rd_addr, rd_lsb};

  // ********************************
  // Write path
  // ********************************

  // Address and direction are taken on the same k rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_state <= b2s_pkg::B2S_W_IDLE;
      wr_addr <= '0;
      wr_lsb <= 1'b0;
    end
    else if (load_ok && !bus_s3.dir_read) // R9
    begin
      // New write: wait for the first beat on the next k rise
      wr_state <= b2s_pkg::B2S_W_BEAT0;
      wr_addr <= bus_s3.addr; // R7
      wr_lsb <= bus_s3.burst_start_bit; // R11
    end
    else if (k_rise && wr_state == b2s_pkg::B2S_W_BEAT0)
    begin
      // First word on k; counter steps linearly to the second word
      wr_state <= b2s_pkg::B2S_W_BEAT1; // R12
      wr_lsb <= ~wr_lsb; // R11
    end
    else if (kn_rise && wr_state == b2s_pkg::B2S_W_BEAT1)
      wr_state <= b2s_pkg::B2S_W_IDLE; // R8
  end

  // A word is written on the k rise of beat 0 or k_n rise of beat 1
  assign wr_en = (k_rise && wr_state == b2s_pkg::B2S_W_BEAT0) ||
                 (kn_rise && wr_state == b2s_pkg::B2S_W_BEAT1); // R1

  // Byte lanes whose select is high keep their old contents
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      for (int i = 0; i < `B2S_LANES; i++)
      begin
        if (!bus_s3.byte_write_sel_n[i])
          mem[wr_idx][i*`B2S_LANE_W +: `B2S_LANE_W] <= bus_s3.dq[i*`B2S_LANE_W +: `B2S_LANE_W]; // R10
      end
    end
  end

  // ********************************
  // Read path
  // ********************************

  // A second read loaded before the first launches replaces it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_state <= b2s_pkg::B2S_R_IDLE;
      rd_addr <= '0;
      rd_lsb <= 1'b0;
      dq_out <= `B2S_DQ_W'(`B2S_DQ_RST);
      dq_oe_n <= 1'b1;
    end
    else if (load_ok && bus_s3.dir_read) // R9
    begin
      rd_state <= b2s_pkg::B2S_R_PEND;
      rd_addr <= bus_s3.addr; // R7
      rd_lsb <= bus_s3.burst_start_bit; // R11
    end
    else
    begin
      unique case (rd_state)
        b2s_pkg::B2S_R_IDLE:
          dq_oe_n <= 1'b1; // R4
        b2s_pkg::B2S_R_PEND:
          // First word goes out on the launch rise
          if (launch_rise)
          begin
            rd_state <= b2s_pkg::B2S_R_BEAT0;
            dq_out <= mem[rd_idx]; // R2
            dq_oe_n <= 1'b0;
            rd_lsb <= ~rd_lsb; // R11
          end
        b2s_pkg::B2S_R_BEAT0:
          // Second word on the following negative launch edge
          if (launch_fall)
          begin
            rd_state <= b2s_pkg::B2S_R_BEAT1;
            dq_out <= mem[rd_idx]; // R12
          end
        b2s_pkg::B2S_R_BEAT1:
          // Burst done: release the bus on the next launch rise
          if (launch_rise)
          begin
            rd_state <= b2s_pkg::B2S_R_IDLE; // R8
            dq_oe_n <= 1'b1; // R4
          end
      endcase
    end
  end

  // ********************************
  // Checks
  // ********************************

  // Helper copy of the word due on the next launch
  logic [`B2S_DQ_W-1:0] rd_word;
  assign rd_word = mem[rd_idx];

  AST_IDLE_TRISTATE: assert property (@(posedge clk) disable iff (rst) // R4
    (rd_state == b2s_pkg::B2S_R_IDLE) ##1 (rd_state == b2s_pkg::B2S_R_IDLE) |-> dq_oe_n)
    else $error("Data drivers enabled with no read selected");

  AST_RD_FIRST: assert property (@(posedge clk) disable iff (rst) // R2
    (launch_rise && rd_state == b2s_pkg::B2S_R_PEND && bus_s3.load_n)
      |=> (!dq_oe_n && dq_out == $past(rd_word)))
    else $error("First read word not driven on launch rise");

  AST_RD_SECOND: assert property (@(posedge clk) disable iff (rst) // R12
    (launch_fall && rd_state == b2s_pkg::B2S_R_BEAT0 && !load_ok)
      |=> (rd_state == b2s_pkg::B2S_R_BEAT1 && dq_out == $past(rd_word) && !dq_oe_n))
    else $error("Second read word not driven on negative launch edge");

  AST_SINGLE_CLK: assert property (@(posedge clk) disable iff (rst) // R3
    (sc_mode && k_rise && rd_state == b2s_pkg::B2S_R_PEND && !load_ok)
      |=> rd_state == b2s_pkg::B2S_R_BEAT0)
    else $error("Single clock mode did not launch on k");

  AST_WR_BEATS: assert property (@(posedge clk) disable iff (rst) // R1
    (k_rise && wr_state == b2s_pkg::B2S_W_BEAT0)
      |-> wr_en ##1 (wr_state == b2s_pkg::B2S_W_BEAT1))
    else $error("Write beat 0 not captured on k rise");

  AST_WR_END: assert property (@(posedge clk) disable iff (rst) // R8
    (kn_rise && wr_state == b2s_pkg::B2S_W_BEAT1 && !load_ok)
      |-> wr_en ##1 (wr_state == b2s_pkg::B2S_W_IDLE))
    else $error("Write burst did not end after two words");

  AST_LOAD_DIR: assert property (@(posedge clk) disable iff (rst) // R9
    (load_ok && bus_s3.dir_read) |=> (rd_state == b2s_pkg::B2S_R_PEND))
    else $error("Read load not registered");

  AST_LOAD_ADDR: assert property (@(posedge clk) disable iff (rst) // R7
    (load_ok && !bus_s3.dir_read)
      |=> (wr_addr == $past(bus_s3.addr) && wr_state == b2s_pkg::B2S_W_BEAT0))
    else $error("Write address not taken with the load");

  AST_BURST_CNT: assert property (@(posedge clk) disable iff (rst) // R11
    (k_rise && wr_state == b2s_pkg::B2S_W_BEAT0 && !load_ok)
      |=> (wr_lsb != $past(wr_lsb)))
    else $error("Burst counter did not step");

endmodule : b2s_data_port
`default_nettype wire

// *** tb/b2s_ctrl_model.sv ***
// Memory controller model: pin clocks, command pins and write data.
// Assumes the bench calls cmd and wr; command pins change only at clk rises.
`timescale 1ns/100ps
`default_nettype none
`include "b2s_params.svh"
module b2s_ctrl_model
(
  // Device system clock
  input wire logic clk,
  // Pin clocks, run free like a real controller's
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  // Command pins and write data
  output var b2s_pkg::b2s_bus_t bus
);
  // ****************************************
  // Clocks and pins
  // ****************************************
  // Offset keeps pin edges clear of clk edges; c trails k by 30 ns
  initial
  begin
    k = 1'b0;
    #1.3;
    forever #62.5 k = ~k;
  end
  initial
  begin
    c = 1'b0;
    #31.3;
    forever #62.5 c = ~c;
  end
  assign k_n = ~k;
  assign c_n = ~c;
  initial bus = '1;
  // Define one bus cycle at a k rise, held four clk rises past it
  task automatic cmd(input logic rd, input logic [4:0] a);
    @(negedge k);
    @(posedge clk);
    bus.load_n <= 1'b0;
    bus.dir_read <= rd;
    bus.addr <= a[4:1];
    bus.burst_start_bit <= a[0];
    @(posedge k);
    repeat (4) @(posedge clk);
    bus.load_n <= 1'b1;
  endtask : cmd
  // Write burst: word 0 at the next k rise, word 1 at the k_n rise after
  task automatic wr(input logic [4:0] a, input logic [`B2S_DQ_W-1:0] w0, w1,
    input logic [1:0] s0, s1);
    cmd(1'b0, a);
    bus.dq <= w0;
    bus.byte_write_sel_n <= s0;
    @(posedge k);
    repeat (4) @(posedge clk);
    bus.dq <= w1;
    bus.byte_write_sel_n <= s1;
    @(posedge k_n);
    repeat (4) @(posedge clk);
    // Released line shows the inverse, never a stale copy
    bus.dq <= ~w1;
    bus.byte_write_sel_n <= 2'h3;
  endtask : wr
endmodule : b2s_ctrl_model
`default_nettype wire

// *** tb/b2s_data_port_tb.sv ***
// Bench for the burst SRAM data port: array model compared at each read.
// Assumes the controller model in b2s_ctrl_model.sv.
`timescale 1ns/100ps
`default_nettype none
`include "b2s_params.svh"
module b2s_data_port_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk, rst, mode, k, k_n, c, c_n, dq_oe_n;
  b2s_pkg::b2s_bus_t bus;
  logic [`B2S_DQ_W-1:0] dq_out, dq_in;
  logic [`B2S_DQ_W-1:0] mem [0:31]; // Expected array contents
  logic [15:0] seed;
  int bad_count, check_count;
  // The wire: device drives while its enable is low
  assign dq_in = dq_oe_n ? bus.dq : dq_out;
  b2s_ctrl_model ctrl_u (.clk(clk), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .bus(bus));
  b2s_data_port dut_u
  (
    .clk(clk), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .single_clk_mode(mode), .load_n(bus.load_n), .dir_read(bus.dir_read),
    .addr(bus.addr), .burst_start_bit(bus.burst_start_bit),
    .byte_write_sel_n(bus.byte_write_sel_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [`B2S_DQ_W-1:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Unselected lanes keep the old byte
  function automatic logic [17:0] lane(input logic [17:0] o, n, input logic [1:0] s);
    lane = {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
  endfunction : lane
  // Next value of the 16-bit shift register behind all random data
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic wr_upd(input logic [4:0] a, input logic [1:0] s0, s1);
    logic [17:0] w0, w1;
    seed = lfsr_next(seed);
    w0 = {seed[1:0], seed};
    w1 = {seed[15:14], ~seed};
    ctrl_u.wr(a, w0, w1, s0, s1);
    mem[a] = lane(mem[a], w0, s0);
    mem[a ^ 5'h1] = lane(mem[a ^ 5'h1], w1, s1);
  endtask : wr_upd
  // Read burst; launch edges follow the clock mode
  task automatic rd_chk(input logic [4:0] a);
    ctrl_u.cmd(1'b1, a);
    if (mode) @(posedge k); else @(posedge c);
    repeat (7) @(negedge clk);
    chk("oe word0", 18'h0, {17'h0, dq_oe_n});
    chk("word0", mem[a], dq_out);
    if (mode) @(posedge k_n); else @(posedge c_n);
    repeat (7) @(negedge clk);
    chk("word1", mem[a ^ 5'h1], dq_out);
    if (mode) @(posedge k); else @(posedge c);
    repeat (7) @(negedge clk);
    chk("oe idle", 18'h1, {17'h0, dq_oe_n});
  endtask : rd_chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang counts as a mismatch
  initial
  begin
    #100000;
    bad_count++;
    $display("test timeout");
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    mode = 1'b0;
    seed = 16'h54c4;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("oe reset", 18'h1, {17'h0, dq_oe_n});
    $display("test reset done");
    // Fill every word, burst start bit random
    for (int i = 0; i < 16; i++) wr_upd({i[3:0], seed[0]}, 2'h0, 2'h0);
    for (int i = 0; i < 32; i++) rd_chk(i[4:0]);
    $display("test fill done");
    // Every lane select pattern on both beats
    for (int s = 0; s < 4; s++)
    begin
      wr_upd({s[1:0], 3'h5}, s[1:0], ~s[1:0]);
      rd_chk({s[1:0], 3'h4});
    end
    $display("test lanes done");
    // Single clock mode: launch on the k clocks
    @(posedge clk);
    mode <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(i[4:0] * 5'h5);
    wr_upd(5'h1f, 2'h0, 2'h2);
    rd_chk(5'h1e);
    $display("test single clock done");
    finish_test();
  end
endmodule : b2s_data_port_tb
`default_nettype wire
